// file: rtl/reset_boot_defs.vh
`ifndef RESET_BOOT_DEFS_VH
`define RESET_BOOT_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------
`define OFF_PULLUP_DISABLE 4'h0
`define OFF_BOOT_STATUS    4'h4
`define OFF_RELEASE_CYCLES 4'h8

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define PUD_BOOT_BIT    0
`define PUD_MEMMODE_BIT 1
`define ST_MODE_BIT     0
`define ST_WIDE_BIT     1
`define ST_SECURED_BIT  2
`define ST_RUN_BIT      3
`define ST_BOOTPIN_BIT  4
`define ST_MEMPIN_BIT   5

// ----------------------------------------------------------------------
// Timing and answers.
// ----------------------------------------------------------------------
`define RELEASE_CYCLES  16'h0040
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define ZERO32          32'h00000000

`endif

// file: rtl/strap_sync.v
`timescale 1ns/1ns

// Two-flop synchroniser for a group of asynchronous levels.
module strap_sync #(
    parameter WIDTH = 3
) (
    input  wire             aclk,
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] rst_val,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ------------------------------------------------------------------
    // Synchroniser chain.
    // ------------------------------------------------------------------
    // Each bit passes two flip-flops; only the second stage is read.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge aclk) begin
                meta_q[i] <= async_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    endgenerate

    assign sync_out = sync_q;

endmodule

// file: rtl/reset_boot_mode_capture.v
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "reset_boot_defs.vh"

// Notes on behaviour
// - While the reset pin is low, the sequencer and mode outputs are initialised and held in reset.
// - On reset pin release, boot source select is latched as operating mode.
// - Internal reset stays asserted a fixed count, then releases on the clock.
// - Boot pin high with unsecured flash selects external boot, else internal.
// - Memory width comes from memory pin, boot pin and flash security.
// - Secured flash ignores a high boot pin and forces internal mode zero.
// - Internal mode zero drives sixteen external address lines.
// - External mode one takes width from the latched memory mode pin.
module reset_boot_mode_capture #(
    parameter [15:0] RELEASE_COUNT = `RELEASE_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ext_reset_n,
    input  wire        test_reset_n,
    input  wire        boot_source_select,
    input  wire        ext_memory_mode_select,
    input  wire        flash_secured,
    output reg         int_reset_n,
    output reg         boot_mode_external,
    output reg         ext_addr_wide,
    output reg         boot_pin_pullup_off,
    output reg         mem_mode_pullup_off,
    input  wire [3:0]  s_axil_awaddr,
    input  wire        s_axil_awvalid,
    output reg         s_axil_awready,
    input  wire [31:0] s_axil_wdata,
    input  wire [3:0]  s_axil_wstrb,
    input  wire        s_axil_wvalid,
    output reg         s_axil_wready,
    output reg  [1:0]  s_axil_bresp,
    output reg         s_axil_bvalid,
    input  wire        s_axil_bready,
    input  wire [3:0]  s_axil_araddr,
    input  wire        s_axil_arvalid,
    output reg         s_axil_arready,
    output reg  [31:0] s_axil_rdata,
    output reg  [1:0]  s_axil_rresp,
    output reg         s_axil_rvalid,
    input  wire        s_axil_rready
);

    // ------------------------------------------------------------------
    // State encoding.
    // ------------------------------------------------------------------
    localparam [2:0] ST_HOLD    = 3'h1;
    localparam [2:0] ST_COUNT   = 3'h2;
    localparam [2:0] ST_RUNNING = 3'h4;

    // ------------------------------------------------------------------
    // Sequencer overview.
    // ------------------------------------------------------------------
    // The reset pin and the test reset are combined into one level.
    // Either one held low holds the whole sequencer in reset.
    // The combined level passes two flip-flops before it is used.
    // The strap pins pass the same two flip-flops beside it.
    // Both therefore reach the logic at the same clock edge.
    // The straps cannot be seen one cycle before the reset release.
    //
    // ST_HOLD is the state in which the pins have just been released.
    // The first edge in this state latches both straps.
    // The flash secured level is latched at the same edge.
    // The secured level comes from logic on this clock.
    // It therefore needs no synchroniser of its own.
    //
    // ST_COUNT counts the fixed number of cycles of the release delay.
    // The delay gives the clocks and the rest of the chip time to settle.
    // The count is a parameter so that a short value may be used.
    // The counter starts at zero and ends one short of the count.
    // The release edge itself is the last cycle of the delay.
    //
    // ST_RUNNING holds the internal reset released.
    // The mode outputs change only at the release edge.
    // They stay unchanged until the next reset of the sequencer.
    // A change of the flash secured level is ignored until then.
    // A change of a strap pin is likewise ignored until then.
    //
    // The mode outputs are forced to zero while reset is held.
    // Logic behind them thus sees internal boot with a narrow bus.
    // This is the safe choice before the straps have been read.
    //
    // ------------------------------------------------------------------
    // Register map overview.
    // ------------------------------------------------------------------
    // Offset zero holds the two pull-up disable bits.
    // Bit zero switches off the pull-up on the boot select pin.
    // Bit one switches off the pull-up on the memory mode pin.
    // Boot software sets a bit only when its pin is tied low.
    // Setting a bit for a pin that floats high would lose its level.
    // These bits are cleared only by the bus reset, not by the pins.
    // Software thus keeps its choice across a pin-driven reset.
    //
    // Offset four reports the latched mode and straps, read only.
    // Offset eight reports the release count, read only.
    // Writes to the read-only places are ignored with an okay answer.
    // Any other offset answers with a slave error on both channels.
    //
    // Only one write and one read are taken at a time.
    // A new address is refused while a response still waits.

    wire [2:0] pins_sync;
    wire       rst_pin_n;
    wire       boot_pin_s;
    wire       mem_pin_s;

    reg  [2:0]  state_q;
    reg  [15:0] count_q;
    reg         boot_pin_lat_q;
    reg         mem_pin_lat_q;
    reg         secured_lat_q;
    reg         aw_held_q;
    reg         w_held_q;
    reg  [3:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg  [31:0] rdata_d;
    reg  [1:0]  rresp_d;

    // ------------------------------------------------------------------
    // Input synchronisation.
    // ------------------------------------------------------------------
    // Reset pin and test reset are combined first; either one resets.
    strap_sync #(
        .WIDTH (3)
    ) u_sync (
        .aclk     (aclk),
        .async_in ({ext_memory_mode_select, boot_source_select,
                    ext_reset_n & test_reset_n}),
        .rst_val  (3'h0),
        .sync_out (pins_sync)
    );

    assign rst_pin_n  = pins_sync[0];
    assign boot_pin_s = pins_sync[1];
    assign mem_pin_s  = pins_sync[2];

    // ------------------------------------------------------------------
    // Reset sequencer and mode capture.
    // ------------------------------------------------------------------
    // Hold while the pin is low, latch straps on release, count, run.
    always @(posedge aclk) begin
        if (!aresetn || !rst_pin_n) begin
            state_q            <= ST_HOLD;
            count_q            <= 16'h0000;
            int_reset_n        <= 1'b0;
            boot_mode_external <= 1'b0;
            ext_addr_wide      <= 1'b0;
        end else begin
            case (state_q)
                ST_HOLD: begin
                    boot_pin_lat_q <= boot_pin_s;
                    mem_pin_lat_q  <= mem_pin_s;
                    secured_lat_q  <= flash_secured;
                    count_q        <= 16'h0000;
                    state_q        <= ST_COUNT;
                end
                ST_COUNT: begin
                    if (count_q >= RELEASE_COUNT - 16'h0001) begin
                        state_q     <= ST_RUNNING;
                        int_reset_n <= 1'b1;
                        // Secured flash forces mode zero.
                        boot_mode_external <= boot_pin_lat_q &
                                              ~secured_lat_q;
                        ext_addr_wide <= boot_pin_lat_q &
                                         ~secured_lat_q &
                                         mem_pin_lat_q;
                    end else begin
                        count_q <= count_q + 16'h0001;
                    end
                end
                ST_RUNNING: begin
                    int_reset_n <= 1'b1;
                end
                default: begin
                    state_q <= ST_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel.
    // ------------------------------------------------------------------
    // Address and data are taken in either order; response follows both.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q           <= 1'b0;
            w_held_q            <= 1'b0;
            aw_addr_q           <= 4'h0;
            w_data_q            <= `ZERO32;
            w_strb_q            <= 4'h0;
            s_axil_awready      <= 1'b0;
            s_axil_wready       <= 1'b0;
            s_axil_bvalid       <= 1'b0;
            s_axil_bresp        <= `RESP_OKAY;
            boot_pin_pullup_off <= 1'b0;
            mem_mode_pullup_off <= 1'b0;
        end else begin
            s_axil_awready <= 1'b0;
            s_axil_wready  <= 1'b0;
            if (s_axil_awvalid && !aw_held_q && !s_axil_awready &&
                !s_axil_bvalid) begin
                s_axil_awready <= 1'b1;
                aw_held_q      <= 1'b1;
                aw_addr_q      <= s_axil_awaddr;
            end
            if (s_axil_wvalid && !w_held_q && !s_axil_wready &&
                !s_axil_bvalid) begin
                s_axil_wready <= 1'b1;
                w_held_q      <= 1'b1;
                w_data_q      <= s_axil_wdata;
                w_strb_q      <= s_axil_wstrb;
            end
            if (aw_held_q && w_held_q && !s_axil_bvalid) begin
                aw_held_q     <= 1'b0;
                w_held_q      <= 1'b0;
                s_axil_bvalid <= 1'b1;
                if (aw_addr_q == `OFF_PULLUP_DISABLE) begin
                    s_axil_bresp <= `RESP_OKAY;
                    if (w_strb_q[0]) begin
                        // Pull-up disable bits for strap pins.
                        boot_pin_pullup_off <=
                            w_data_q[`PUD_BOOT_BIT];
                        mem_mode_pullup_off <=
                            w_data_q[`PUD_MEMMODE_BIT];
                    end
                end else if (aw_addr_q == `OFF_BOOT_STATUS ||
                             aw_addr_q == `OFF_RELEASE_CYCLES) begin
                    s_axil_bresp <= `RESP_OKAY;         // Read-only.
                end else begin
                    s_axil_bresp <= `RESP_SLVERR;
                end
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data decode.
    // ------------------------------------------------------------------
    always @* begin
        rdata_d = `ZERO32;
        rresp_d = `RESP_OKAY;
        case (s_axil_araddr)
            `OFF_PULLUP_DISABLE: begin
                rdata_d[`PUD_BOOT_BIT]    = boot_pin_pullup_off;
                rdata_d[`PUD_MEMMODE_BIT] = mem_mode_pullup_off;
            end
            `OFF_BOOT_STATUS: begin
                rdata_d[`ST_MODE_BIT]    = boot_mode_external;
                rdata_d[`ST_WIDE_BIT]    = ext_addr_wide;
                rdata_d[`ST_SECURED_BIT] = secured_lat_q;
                rdata_d[`ST_RUN_BIT]     = int_reset_n;
                rdata_d[`ST_BOOTPIN_BIT] = boot_pin_lat_q;
                rdata_d[`ST_MEMPIN_BIT]  = mem_pin_lat_q;
            end
            `OFF_RELEASE_CYCLES: begin
                rdata_d[15:0] = RELEASE_COUNT;
            end
            default: begin
                rresp_d = `RESP_SLVERR;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel.
    // ------------------------------------------------------------------
    // Address taken one cycle after arvalid, data in the same cycle as arready.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_arready <= 1'b0;
            s_axil_rvalid  <= 1'b0;
            s_axil_rdata   <= `ZERO32;
            s_axil_rresp   <= `RESP_OKAY;
        end else begin
            s_axil_arready <= 1'b0;
            if (s_axil_arvalid && !s_axil_arready && !s_axil_rvalid) begin
                s_axil_arready <= 1'b1;
                s_axil_rvalid  <= 1'b1;
                s_axil_rdata   <= rdata_d;
                s_axil_rresp   <= rresp_d;
            end else if (s_axil_rvalid && s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: tb/board_straps.sv
`timescale 1ns/1ns

// --------------------
// Board reset and straps
// --------------------
module board_straps (
    input  logic hold,
    input  logic boot_low,
    input  logic mem_low,
    output logic ext_reset_n,
    output logic test_reset_n,
    output logic boot_source_select,
    output logic ext_memory_mode_select
);
    // Both reset lines move together, off the clock edge.
    assign #7 ext_reset_n = !hold;
    assign #7 test_reset_n = !hold;
    // Straps are tied hard to supply or ground.
    assign #7 boot_source_select = !boot_low;
    assign #7 ext_memory_mode_select = !mem_low;
endmodule

// file: tb/reset_boot_checker.sv
`timescale 1ns/1ns

// --------------------
// Sequencer checks
// --------------------
module reset_boot_checker #(
    parameter [15:0] RELEASE_COUNT = 16'h0040
) (
    input logic aclk,
    input logic aresetn,
    input logic ext_reset_n,
    input logic test_reset_n,
    input logic boot_source_select,
    input logic ext_memory_mode_select,
    input logic flash_secured,
    input logic int_reset_n,
    input logic boot_mode_external,
    input logic ext_addr_wide
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] hi_q;
    // Counts cycles with both reset pins high, saturating.
    // A bus reset alone does not restart it, since the pins stay high.
    always @(posedge aclk) begin
        if (!ext_reset_n || !test_reset_n)
            hi_q <= 16'h0000;
        else if (hi_q != 16'hFFFF)
            hi_q <= hi_q + 16'h0001;
    end
    a_pin_holds: assert property ((!ext_reset_n)[*4] |-> !int_reset_n)
        else $error("internal reset not held by pin");
    a_test_holds: assert property ((!test_reset_n)[*4] |-> !int_reset_n)
        else $error("internal reset not held by test reset");
    a_rel_early: assert property ($rose(int_reset_n) |->
        hi_q >= RELEASE_COUNT + 16'h0002) else $error("release too early");
    a_rel_late: assert property (hi_q == RELEASE_COUNT + 16'h0007
        |-> int_reset_n) else $error("release too late");
    a_mode_ext: assert property ($rose(int_reset_n) |->
        boot_mode_external == (boot_source_select && !flash_secured))
        else $error("boot mode wrong");
    a_mode_wide: assert property ($rose(int_reset_n) |->
        ext_addr_wide == (boot_source_select && ext_memory_mode_select
        && !flash_secured)) else $error("bus width wrong");
    a_mode_kept: assert property (int_reset_n && $past(int_reset_n) |->
        $stable({boot_mode_external, ext_addr_wide}))
        else $error("latched mode changed");
    a_mode_zero: assert property (!int_reset_n |->
        !boot_mode_external && !ext_addr_wide) else $error("mode not cleared");
endmodule

bind reset_boot_mode_capture reset_boot_checker #(
    .RELEASE_COUNT(RELEASE_COUNT)) i_reset_boot_checker (.*);

// file: tb/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb;
    localparam [15:0] RC = 16'h0004;
    logic aclk, aresetn, hold, boot_low, mem_low, flash_secured;
    logic ext_reset_n, test_reset_n, boot_source_select;
    logic ext_memory_mode_select, int_reset_n, boot_mode_external;
    logic ext_addr_wide, boot_pin_pullup_off, mem_mode_pullup_off;
    logic [3:0] s_axil_awaddr, s_axil_araddr, s_axil_wstrb;
    logic [31:0] s_axil_wdata, s_axil_rdata, d;
    logic [1:0] s_axil_bresp, s_axil_rresp, r;
    logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
    logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
    logic s_axil_rvalid, s_axil_rready;
    int errors, n_compared;

    reset_boot_mode_capture #(.RELEASE_COUNT(RC))
        i_reset_boot_mode_capture (.*);
    board_straps i_board_straps (.*);

    // Free-running system clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Prints the counts and the verdict, then stops.
    task wrap_up;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Register write; each channel is released once taken.
    task wr(input [3:0] a, input [31:0] v, input [3:0] s);
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= v;
        s_axil_wstrb <= s;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
        end while (s_axil_bvalid !== 1'b1);
        r = s_axil_bresp;
        s_axil_bready <= 1'b0;
    endtask

    // Register read; data and response land in d and r.
    task rd(input [3:0] a);
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
        end while (s_axil_rvalid !== 1'b1);
        d = s_axil_rdata;
        r = s_axil_rresp;
        s_axil_rready <= 1'b0;
    endtask

    // One board reset with given straps, then a strap change after it.
    task t_boot(input b, input m, input s);
        int n;
        @(posedge aclk);
        hold <= 1'b1;
        boot_low <= !b;
        mem_low <= !m;
        flash_secured <= s;
        repeat (6) @(posedge aclk);
        `CHK("held", 1'b0, int_reset_n)
        hold <= 1'b0;
        repeat (RC) @(posedge aclk);
        `CHK("count", 1'b0, int_reset_n)
        n = 0;
        while (int_reset_n !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        `CHK("release", 1'b1, int_reset_n)
        `CHK("ext", b & !s, boot_mode_external)
        `CHK("wide", b & m & !s, ext_addr_wide)
        boot_low <= b;
        mem_low <= m;
        flash_secured <= !s;
        wr(4'h0, {30'h0, !m, !b}, 4'hF);
        @(posedge aclk);
        `CHK("pu", {!m, !b}, {mem_mode_pullup_off, boot_pin_pullup_off})
        rd(4'h4);
        `CHK("status", {m, b, 1'b1, s, b & m & !s, b & !s}, d[5:0])
    endtask

    // Strobes, read-only and unmapped places, and a bus reset.
    task t_regs;
        wr(4'h0, 32'h00000003, 4'hF);
        wr(4'h0, 32'h00000000, 4'h0);
        rd(4'h0);
        `CHK("strb", 32'h00000003, d)
        wr(4'h4, 32'hFFFFFFFF, 4'hF);
        `CHK("ro", 2'h0, r)
        rd(4'h8);
        `CHK("count_reg", {16'h0000, RC}, d)
        wr(4'hC, 32'h00000001, 4'hF);
        `CHK("bad_wr", 2'h2, r)
        rd(4'hC);
        `CHK("bad_rd", 34'h200000000, {r, d})
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0);
        `CHK("pu_clr", 32'h00000000, d)
    endtask

    // Main sequence.
    initial begin
        aresetn = 1'b0;
        hold = 1'b1;
        boot_low = 1'b0;
        mem_low = 1'b0;
        flash_secured = 1'b0;
        {s_axil_awaddr, s_axil_araddr, s_axil_wstrb, s_axil_wdata} = '0;
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
        {s_axil_arvalid, s_axil_rready} = '0;
        errors = 0;
        n_compared = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_boot(1'b1, 1'b1, 1'b0);
        t_boot(1'b1, 1'b0, 1'b0);
        t_boot(1'b0, 1'b1, 1'b0);
        t_boot(1'b0, 1'b0, 1'b0);
        t_boot(1'b1, 1'b1, 1'b1);
        t_regs;
        wrap_up;
    end

    // Watchdog against a hung handshake.
    initial begin
        #100000;
        errors++;
        wrap_up;
    end
endmodule
